// ---- core/dsc_pkg.sv ----
//
// Function
// - With the pin direction bit at 0 the data pin is only ever an input during data transfer.
// - With the pin direction bit at 1 the data pin follows the read flag of the instruction.
// - The bit order bit chooses whether instruction and data shift LSB or MSB first.
// - Writing 1 to the software reset bit returns the configuration registers other than address 0 to default.
// - The software reset bit always reads back as 0.
// - The software reset leaves the bits at address 0 unchanged.
// - The hardware reset forces every register, address 0 included, to default.
// - The output current shutdown bit switches off both channel output currents.
// - The power-down bit halts every analog and digital function except the serial port.
// - The resistor select bit chooses two separate resistors at 0 and one shared at 1.
// - While the synthesizer is enabled bit 1 of address 0 reads its lock state.
// - Address 1 bits 7:6 pick the interpolation factor: 00 one, 01 two, 10 four.
// - Code 11 of the interpolation field picks a factor of eight.
//
package dsc_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [4:0] ADDR_SERIAL_POWER = 5'h00;
   localparam logic [4:0] ADDR_FILTER_MOD = 5'h01;
   localparam logic [7:0] SERIAL_POWER_RESET = 8'h00;
   localparam logic [7:0] FILTER_MOD_RESET = 8'h00;
   // ------------------------------------------------------------
   // Field positions, address 0
   // ------------------------------------------------------------
   localparam int BIT_PIN_BIDIR = 7;
   localparam int BIT_LSB_FIRST = 6;
   localparam int BIT_SOFT_RESET = 5;
   localparam int BIT_OUTPUTS_OFF = 4;
   localparam int BIT_POWER_DOWN = 3;
   localparam int BIT_REF_RES_SELECT = 2;
   localparam int BIT_LOCK_STATUS = 1;
   // Mask of the bits that address 0 stores
   localparam logic [7:0] SERIAL_POWER_STORED = 8'hdc;
   // ------------------------------------------------------------
   // Field positions, address 1 and instruction byte
   // ------------------------------------------------------------
   localparam int INTERP_HI = 7;
   localparam int INTERP_LO = 6;
   localparam int INSTR_READ_BIT = 7;
   localparam int INSTR_ADDR_HI = 4;
   // ------------------------------------------------------------
   // Serial frame and interpolation factors
   // ------------------------------------------------------------
   localparam logic [3:0] LAST_INSTR_EDGE = 4'h7;
   localparam logic [3:0] LAST_DATA_EDGE = 4'hf;
   localparam logic [3:0] FACTOR_1X = 4'h1;
   localparam logic [3:0] FACTOR_2X = 4'h2;
   localparam logic [3:0] FACTOR_4X = 4'h4;
   localparam logic [3:0] FACTOR_8X = 4'h8;
endpackage

// ---- core/dsc_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsc_regs (
   // System side
   input wire logic clock,
   input wire logic sys_rst,
   // Serial port from the host
   input wire logic serial_clock,
   input wire logic select_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   output logic sdo,
   // Synthesizer status, asynchronous
   input wire logic pll_enabled,
   input wire logic pll_locked,
   // Controls to the converter core
   output logic dac_outputs_off,
   output logic power_down,
   output logic reference_resistor_select,
   output logic [1:0] interp_code,
   output logic [3:0] interp_factor,
   output logic [7:0] filter_mod_ctl
);
   // ------------------------------------------------------------
   // Decoders
   // ------------------------------------------------------------
   function automatic logic [3:0] factor_of(input logic [1:0] code);
      unique case (code)
         2'b00: factor_of = dsc_pkg::FACTOR_1X;
         2'b01: factor_of = dsc_pkg::FACTOR_2X;
         2'b10: factor_of = dsc_pkg::FACTOR_4X;
         2'b11: factor_of = dsc_pkg::FACTOR_8X;
      endcase
   endfunction

   function automatic logic [7:0] reverse8(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         reverse8[i] = v[7-i];
      end
   endfunction

   // ------------------------------------------------------------
   // System domain registers
   // ------------------------------------------------------------
   logic [7:0] serial_power;
   logic [7:0] filter_mod;
   logic [7:0] wr_data_hold;
   logic [4:0] wr_addr_hold;
   logic wr_toggle = 1'b0;
   logic [2:0] wr_sync;
   logic [1:0] en_sync;
   logic [1:0] lock_sync;

   wire wr_event = wr_sync[2] ^ wr_sync[1];
   wire wr_reg0 = wr_event && (wr_addr_hold == dsc_pkg::ADDR_SERIAL_POWER);
   wire wr_reg1 = wr_event && (wr_addr_hold == dsc_pkg::ADDR_FILTER_MOD);
   wire soft_reset = wr_reg0 && wr_data_hold[dsc_pkg::BIT_SOFT_RESET];
   wire lock_seen = en_sync[1] && lock_sync[1];
   wire [7:0] next_serial_power = wr_data_hold & dsc_pkg::SERIAL_POWER_STORED;
   wire [1:0] interp_now = filter_mod[dsc_pkg::INTERP_HI:dsc_pkg::INTERP_LO];

   // Write strobe crossing keeps shifting through reset, so all stages
   // agree on release and a toggle left from before is never replayed
   always_ff @(posedge clock) begin
      wr_sync <= {wr_sync[1:0], wr_toggle};
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         en_sync <= 2'h0;
      end else begin
         en_sync <= {en_sync[0], pll_enabled};
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         lock_sync <= 2'h0;
      end else begin
         lock_sync <= {lock_sync[0], pll_locked};
      end
   end

   // ------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------
   // Address 0 survives the soft reset; only the pin reset clears it
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         serial_power <= dsc_pkg::SERIAL_POWER_RESET;
      end else if (wr_reg0) begin
         serial_power <= next_serial_power;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst || soft_reset) begin
         filter_mod <= dsc_pkg::FILTER_MOD_RESET;
      end else if (wr_reg1) begin
         filter_mod <= wr_data_hold;
      end
   end

   // ------------------------------------------------------------
   // Control outputs
   // ------------------------------------------------------------
   // Registered so the converter core never sees a decode glitch
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         dac_outputs_off <= 1'b0;
      end else begin
         dac_outputs_off <= serial_power[dsc_pkg::BIT_OUTPUTS_OFF];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         power_down <= 1'b0;
      end else begin
         power_down <= serial_power[dsc_pkg::BIT_POWER_DOWN];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reference_resistor_select <= 1'b0;
      end else begin
         reference_resistor_select <= serial_power[dsc_pkg::BIT_REF_RES_SELECT];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         interp_code <= 2'b00;
      end else begin
         interp_code <= interp_now;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         interp_factor <= dsc_pkg::FACTOR_1X;
      end else begin
         interp_factor <= factor_of(interp_now);
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         filter_mod_ctl <= dsc_pkg::FILTER_MOD_RESET;
      end else begin
         filter_mod_ctl <= filter_mod;
      end
   end

   // Read images; soft reset bit and reserved bit 0 are never stored
   wire [7:0] img0 = serial_power | {6'h00, lock_seen, 1'b0};
   logic [7:0] img0_q;
   logic [7:0] img1_q;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         img0_q <= dsc_pkg::SERIAL_POWER_RESET;
      end else begin
         img0_q <= img0;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         img1_q <= dsc_pkg::FILTER_MOD_RESET;
      end else begin
         img1_q <= filter_mod;
      end
   end

   // ------------------------------------------------------------
   // Link domain: quasi-static copies of the read images
   // ------------------------------------------------------------
   // These settle over the instruction byte; a register changed by
   // the hardware mid-frame may read old or new, never a mix per bit
   // beyond what two edges allow.
   logic [7:0] m0_meta;
   logic [7:0] m0;
   logic [7:0] m1_meta;
   logic [7:0] m1;
   always_ff @(posedge serial_clock) begin
      m0_meta <= img0_q;
      m0 <= m0_meta;
   end

   always_ff @(posedge serial_clock) begin
      m1_meta <= img1_q;
      m1 <= m1_meta;
   end

   wire lsb_first = m0[dsc_pkg::BIT_LSB_FIRST];
   wire bidir = m0[dsc_pkg::BIT_PIN_BIDIR];

   // ------------------------------------------------------------
   // Link domain: frame shifter, cleared by the frame's own select
   // ------------------------------------------------------------
   logic [3:0] edge_count;
   logic [7:0] shift;
   logic [7:0] instr;
   logic frame_done;
   wire [7:0] shift_in = {shift[6:0], sdio_in};
   wire [7:0] byte_in = lsb_first ? reverse8(shift_in) : shift_in;

   wire instr_end = (edge_count == dsc_pkg::LAST_INSTR_EDGE);
   wire data_end = (edge_count == dsc_pkg::LAST_DATA_EDGE);
   wire shifting = !frame_done;

   // Select high is the only reset here; a cut frame leaves no trace
   always_ff @(posedge serial_clock or posedge select_n) begin
      if (select_n) begin
         edge_count <= 4'h0;
      end else if (shifting) begin
         edge_count <= edge_count + 4'h1;
      end
   end

   always_ff @(posedge serial_clock or posedge select_n) begin
      if (select_n) begin
         shift <= 8'h00;
      end else if (shifting) begin
         shift <= shift_in;
      end
   end

   always_ff @(posedge serial_clock or posedge select_n) begin
      if (select_n) begin
         instr <= 8'h00;
      end else if (shifting && instr_end) begin
         instr <= byte_in;
      end
   end

   always_ff @(posedge serial_clock or posedge select_n) begin
      if (select_n) begin
         frame_done <= 1'b0;
      end else if (shifting && data_end) begin
         frame_done <= 1'b1;
      end
   end

   wire is_read = instr[dsc_pkg::INSTR_READ_BIT];
   wire [4:0] addr = instr[dsc_pkg::INSTR_ADDR_HI:0];
   wire in_data = (edge_count > dsc_pkg::LAST_INSTR_EDGE) || frame_done;
   wire wr_commit = !frame_done && !is_read && (edge_count == dsc_pkg::LAST_DATA_EDGE)
                    && (edge_count > dsc_pkg::LAST_INSTR_EDGE);

   // ------------------------------------------------------------
   // Link domain: write hand-over
   // ------------------------------------------------------------
   // Hold registers stay put until the next write frame, long after
   // the system side has taken them on the toggle.
   always_ff @(posedge serial_clock) begin
      if (wr_commit && !select_n) begin
         wr_data_hold <= byte_in;
         wr_addr_hold <= addr;
         wr_toggle <= ~wr_toggle;
      end
   end

   // ------------------------------------------------------------
   // Link domain: read driver on the falling edge
   // ------------------------------------------------------------
   wire [7:0] rd_byte = (addr == dsc_pkg::ADDR_SERIAL_POWER) ? m0 :
                        (addr == dsc_pkg::ADDR_FILTER_MOD) ? m1 : 8'h00;
   wire [2:0] bit_index = edge_count[2:0];
   wire rd_bit = lsb_first ? rd_byte[bit_index] : rd_byte[3'h7 - bit_index];
   wire driving = is_read && in_data && !frame_done;
   wire drive_sdio = driving && bidir;

   // Launched on the falling edge so the host gets half a period of setup
   always_ff @(negedge serial_clock or posedge select_n) begin
      if (select_n) begin
         sdio_out <= 1'b0;
      end else begin
         sdio_out <= driving ? rd_bit : 1'b0;
      end
   end

   always_ff @(negedge serial_clock or posedge select_n) begin
      if (select_n) begin
         sdio_oe <= 1'b0;
      end else begin
         sdio_oe <= drive_sdio;
      end
   end

   always_ff @(negedge serial_clock or posedge select_n) begin
      if (select_n) begin
         sdo <= 1'b0;
      end else begin
         sdo <= driving ? rd_bit : 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- tb/dsc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsc_host (
   // Serial port toward the device
   output logic serial_clock,
   output logic select_n,
   output logic sdio_in,
   input wire logic sdio_out,
   input wire logic sdio_oe,
   input wire logic sdo
);
   logic hdrv;
   // Device wins the two-way pin while it drives
   assign sdio_in = sdio_oe ? sdio_out : hdrv;
   initial begin
      serial_clock = 1'b0;
      select_n = 1'b1;
      hdrv = 1'b0;
   end
   // Serial clock stands still outside frames
   task automatic xfer(input logic [7:0] ins, input logic [7:0] d, input bit lsb,
      output logic [7:0] q, output logic oe);
      int i;
      int b;
      q = 8'h00;
      oe = 1'b0;
      select_n = 1'b0;
      for (i = 0; i < 16; i++) begin
         b = lsb ? i % 8 : 7 - i % 8;
         hdrv = i < 8 ? ins[b] : d[b];
         #62.5 serial_clock = 1'b1;
         if (i > 7) begin
            q[b] = sdio_oe ? sdio_in : sdo;
            oe |= sdio_oe;
         end
         #62.5 serial_clock = 1'b0;
      end
      #5 select_n = 1'b1;
      hdrv = ~hdrv;
      #400;
   endtask
endmodule
`default_nettype wire

// ---- tb/dsc_regs_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsc_regs_asserts (
   // System side
   input wire logic clock,
   input wire logic sys_rst,
   // Serial port
   input wire logic serial_clock,
   input wire logic select_n,
   input wire logic sdio_out,
   input wire logic sdio_oe,
   input wire logic sdo,
   // Controls
   input wire logic dac_outputs_off,
   input wire logic power_down,
   input wire logic reference_resistor_select,
   input wire logic [1:0] interp_code,
   input wire logic [3:0] interp_factor,
   input wire logic [7:0] filter_mod_ctl
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   sequence rst_release;
      sys_rst ##1 !sys_rst;
   endsequence
   factor_map_a: assert property (interp_factor == (4'h1 << interp_code))
      else $error("factor does not match code");
   factor_hot_a: assert property ($onehot(interp_factor))
      else $error("factor not one-hot");
   code_field_a: assert property (interp_code == filter_mod_ctl[7:6])
      else $error("code differs from register");
   // Reset checks must not be masked by the reset itself
   reset_clear_a: assert property (disable iff (1'b0) sys_rst |=> !power_down &&
      !dac_outputs_off && !reference_resistor_select && filter_mod_ctl == 8'h00)
      else $error("reset left a control set");
   reset_release_a: assert property (disable iff (1'b0) rst_release |->
      interp_factor == 4'h1 && !power_down && filter_mod_ctl == 8'h00)
      else $error("control set after reset release");
   ctl_frame_a: assert property ($changed({power_down, dac_outputs_off,
      reference_resistor_select, filter_mod_ctl}) && !$past(sys_rst) |-> $past(select_n))
      else $error("control moved inside a frame");
   idle_quiet_a: assert property (select_n && $past(select_n) |->
      !sdo && !sdio_oe && !sdio_out)
      else $error("serial driver active outside frame");
   oe_data_a: assert property (@(posedge serial_clock) disable iff (select_n)
      sdio_oe |-> sdio_out == sdo)
      else $error("two-way pin and sdo disagree");
endmodule
bind dsc_regs dsc_regs_asserts u_dsc_regs_asserts (.clock, .sys_rst, .serial_clock,
   .select_n, .sdio_out, .sdio_oe, .sdo, .dac_outputs_off, .power_down,
   .reference_resistor_select, .interp_code, .interp_factor, .filter_mod_ctl);
`default_nettype wire

// ---- tb/dsc_regs_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsc_regs_bench;
   logic clock, sys_rst, pll_enabled, pll_locked, oe;
   logic serial_clock, select_n, sdio_in, sdio_out, sdio_oe, sdo;
   logic dac_outputs_off, power_down, reference_resistor_select;
   logic [1:0] interp_code;
   logic [3:0] interp_factor;
   logic [7:0] filter_mod_ctl, q;
   bit lsb;
   int n_mismatch, n_checks, k;
   wire logic [7:0] ctl = {1'b0, dac_outputs_off, power_down, reference_resistor_select,
      interp_factor};
   dsc_regs u_dsc_regs (.clock, .sys_rst, .serial_clock, .select_n, .sdio_in, .sdio_out,
      .sdio_oe, .sdo, .pll_enabled, .pll_locked, .dac_outputs_off, .power_down,
      .reference_resistor_select, .interp_code, .interp_factor, .filter_mod_ctl);
   dsc_host u_dsc_host (.serial_clock, .select_n, .sdio_in, .sdio_out, .sdio_oe, .sdo);
   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [4:0] a, logic [7:0] d);
      u_dsc_host.xfer({3'h0, a}, d, lsb, q, oe);
   endtask
   task automatic rd(logic [4:0] a);
      u_dsc_host.xfer({3'h4, a}, 8'hff, lsb, q, oe);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Whole run is about 51 us of frames
   initial begin
      #200000;
      n_mismatch++;
      final_report;
   end
   // ---------------------------------------------
   // Tests
   // ---------------------------------------------
   initial begin
      sys_rst = 1'b1;
      pll_enabled = 1'b0;
      pll_locked = 1'b0;
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clock);
      check("ctl", ctl, 8'h01);
      rd(5'h00);
      check("addr0", q, 8'h00);
      check("oe", {7'h00, oe}, 8'h00);
      $display("test reset done");
      for (k = 0; k < 4; k++) begin
         wr(5'h01, {k[1:0], 6'h15});
         check("ctl", ctl, 8'h01 << k);
         rd(5'h01);
         check("addr1", q, {k[1:0], 6'h15});
      end
      $display("test interp done");
      wr(5'h00, 8'h1c);
      check("ctl", ctl, 8'h78);
      @(posedge clock);
      pll_locked <= 1'b1;
      rd(5'h00);
      check("addr0", q, 8'h1c);
      @(posedge clock);
      pll_enabled <= 1'b1;
      rd(5'h00);
      check("addr0", q, 8'h1e);
      wr(5'h00, 8'h3c);
      check("ctl", ctl, 8'h71);
      rd(5'h00);
      check("addr0", q, 8'h1e);
      rd(5'h1f);
      check("unmapped", q, 8'h00);
      $display("test controls done");
      wr(5'h00, 8'h80);
      rd(5'h00);
      check("addr0", q, 8'h82);
      check("oe", {7'h00, oe}, 8'h01);
      wr(5'h00, 8'hc0);
      lsb = 1'b1;
      rd(5'h00);
      check("addr0", q, 8'hc2);
      wr(5'h01, 8'h81);
      check("filt", filter_mod_ctl, 8'h81);
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clock);
      check("ctl", ctl, 8'h01);
      lsb = 1'b0;
      rd(5'h00);
      check("addr0", q, 8'h02);
      check("oe", {7'h00, oe}, 8'h00);
      $display("test order done");
      final_report;
   end
endmodule
`default_nettype wire
